// >>> design/adcc_top.sv
// Converter control: registers on APB, bit-period divider, successive-approximation sequencer.
// Assumes an analog front end that compares the held sample against code_o and returns comp_i.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "adcc_defs.svh"

module adcc_top
   import adcc_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic comp_i,
   output logic [9:0] code_o,
   output logic sample_o,
   output logic converter_enable_o,
   output logic reference_select_o,
   output logic [2:0] channel_select_o,
   output logic converter_interrupt_flag_o
);

   adcc_regs_t q, d;
   logic tick;
   logic wr;
   logic done;
   logic [7:0] rd_byte;
   logic hit;

   // Bit-period strobe from the latched clock select
   assign tick = (q.div_cnt == 8'(adcc_tad_cycles(q.act.clk_sel) - 8'h01));
   assign wr = psel_i && penable_i && pwrite_i && q.apb.pready;

   // Read decode for the setup phase
   always_comb begin
      rd_byte = 8'h00;
      hit = 1'b1;
      if (paddr_i == `ADCC_OFF_MAIN) begin
         rd_byte = {q.main.justify, q.main.ref_sel, 1'b0, q.main.chan, q.main.go, q.main.en};
      end else if (paddr_i == `ADCC_OFF_CLKSEL) begin
         rd_byte = {1'b0, q.clk_sel, 4'h0};
      end else if (paddr_i == `ADCC_OFF_RESH) begin
         rd_byte = q.res_hi;
      end else if (paddr_i == `ADCC_OFF_RESL) begin
         rd_byte = q.res_lo;
      end else if (paddr_i == `ADCC_OFF_FLAG) begin
         rd_byte = {7'h00, q.flag};
      end else begin
         hit = 1'b0;
      end
   end

   always_comb begin
      d = q;
      done = 1'b0;
      d.apb.pready = 1'b0;
      d.apb.pslverr = 1'b0;

      // Answer is prepared in setup so the access phase completes at once
      if (psel_i && !penable_i) begin
         d.apb.pready = 1'b1;
         d.apb.pslverr = !hit;
         d.apb.prdata = {24'h000000, rd_byte};
      end

      // Bit-period divider runs only while busy
      if (q.st != ST_IDLE) begin
         d.div_cnt = tick ? 8'h00 : 8'(q.div_cnt + 8'h01);
      end

      case (q.st)
         ST_IDLE: begin
         end
         ST_SAMP: begin
            if (tick) begin
               d.st = ST_CONV;
               d.bit_idx = 4'h9;
               d.code = 10'h200;
            end
         end
         ST_CONV: begin
            if (tick) begin
               if (!comp_i) begin
                  d.code[q.bit_idx] = 1'b0;
               end
               if (q.bit_idx == 4'h0) begin
                  done = 1'b1;
               end else begin
                  d.bit_idx = 4'(q.bit_idx - 4'h1);
                  d.code[4'(q.bit_idx - 4'h1)] = 1'b1;
               end
            end
         end
         ST_ABORT: begin
            if (tick) begin
               if (q.bit_idx == 4'h1) begin
                  d.st = ST_IDLE;
               end else begin
                  d.bit_idx = 4'(q.bit_idx + 4'h1);
               end
            end
         end
         default: begin
            d.st = ST_IDLE;
         end
      endcase

      // Register writes
      if (wr) begin
         if (paddr_i == `ADCC_OFF_MAIN) begin
            d.main.justify = pwdata_i[`ADCC_MAIN_JUSTIFY];
            d.main.ref_sel = pwdata_i[`ADCC_MAIN_REF];
            d.main.chan = pwdata_i[`ADCC_MAIN_CHAN_HI:`ADCC_MAIN_CHAN_LO];
            d.main.en = pwdata_i[`ADCC_MAIN_EN];
            if (!pwdata_i[`ADCC_MAIN_EN]) begin
               d.main.go = 1'b0;
               d.st = ST_IDLE;
               d.div_cnt = 8'h00;
            end else if (pwdata_i[`ADCC_MAIN_GO] && q.main.en && q.st == ST_IDLE) begin
               d.main.go = 1'b1;
               d.st = ST_SAMP;
               d.div_cnt = 8'h00;
               d.act.ref_sel = pwdata_i[`ADCC_MAIN_REF];
               d.act.chan = pwdata_i[`ADCC_MAIN_CHAN_HI:`ADCC_MAIN_CHAN_LO];
               d.act.clk_sel = q.clk_sel;
            end else if (!pwdata_i[`ADCC_MAIN_GO] && q.main.go && !done) begin
               d.main.go = 1'b0;
               d.st = ST_ABORT;
               d.bit_idx = 4'h0;
               d.div_cnt = 8'h00;
            end
         end else if (paddr_i == `ADCC_OFF_CLKSEL) begin
            d.clk_sel = pwdata_i[`ADCC_CLKSEL_HI:`ADCC_CLKSEL_LO];
         end else if (paddr_i == `ADCC_OFF_RESH) begin
            d.res_hi = pwdata_i[7:0];
         end else if (paddr_i == `ADCC_OFF_RESL) begin
            d.res_lo = pwdata_i[7:0];
         end else if (paddr_i == `ADCC_OFF_FLAG) begin
            if (pwdata_i[`ADCC_FLAG_BIT]) begin
               d.flag = 1'b0;
            end
         end
      end

      // Completion wins over any same-cycle clear or result write
      if (done) begin
         d.st = ST_IDLE;
         d.main.go = 1'b0;
         d.flag = 1'b1;
         if (q.main.justify) begin
            d.res_hi = {6'h00, d.code[9:8]};
            d.res_lo = d.code[7:0];
         end else begin
            d.res_hi = d.code[9:2];
            d.res_lo = {d.code[1:0], 6'h00};
         end
      end

      // While idle the active settings track the registers
      if (d.st == ST_IDLE) begin
         d.act.ref_sel = d.main.ref_sel;
         d.act.chan = d.main.chan;
         d.act.clk_sel = d.clk_sel;
      end

      d.conv_en = d.main.en;
      d.sample = d.main.en && (d.st == ST_IDLE || d.st == ST_SAMP);
      d.out_cfg = d.act;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '0;
         q.st <= ST_IDLE;
         q.main <= 7'(`ADCC_MAIN_RST);
         q.clk_sel <= `ADCC_CLKSEL_RST;
         q.res_hi <= `ADCC_RES_RST;
         q.res_lo <= `ADCC_RES_RST;
      end else if (clk_en_i) begin
         q <= d;
      end
   end

   assign prdata_o = q.apb.prdata;
   assign pready_o = q.apb.pready;
   assign pslverr_o = q.apb.pslverr;
   assign code_o = q.code;
   assign sample_o = q.sample;
   assign converter_enable_o = q.conv_en;
   assign reference_select_o = q.out_cfg.ref_sel;
   assign channel_select_o = q.out_cfg.chan;
   assign converter_interrupt_flag_o = q.flag;

   // Checks
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   logic wr_main;
   assign wr_main = wr && clk_en_i && paddr_i == `ADCC_OFF_MAIN;

   chk_go_ignored_off: assert property (
      wr_main && !q.main.en && pwdata_i[`ADCC_MAIN_GO] |=> !q.main.go && q.st == ST_IDLE)
      else $error("go accepted while converter disabled");

   chk_go_starts: assert property (
      wr_main && q.main.en && pwdata_i[`ADCC_MAIN_EN] && pwdata_i[`ADCC_MAIN_GO] && q.st == ST_IDLE
      |=> q.st == ST_SAMP && q.main.go)
      else $error("go did not start a conversion");

   chk_done_flags: assert property (
      clk_en_i && q.st == ST_CONV && tick && q.bit_idx == 4'h0 |=> !q.main.go && q.flag && q.st == ST_IDLE)
      else $error("completion did not clear go and set flag");

   chk_abort_keeps: assert property (
      wr_main && pwdata_i[`ADCC_MAIN_EN] && !pwdata_i[`ADCC_MAIN_GO] && q.main.go && !done
      |=> q.st == ST_ABORT && $stable(q.res_hi) && $stable(q.res_lo))
      else $error("abort changed result or missed delay");

   chk_left_format: assert property (
      clk_en_i && done && !q.main.justify |=> q.res_hi == $past(d.code[9:2]) && q.res_lo[5:0] == 6'h00)
      else $error("left justified result misplaced");

   chk_right_format: assert property (
      clk_en_i && done && q.main.justify |=> q.res_hi[7:2] == 6'h00 && q.res_lo == $past(d.code[7:0]))
      else $error("right justified result misplaced");

   chk_cfg_held: assert property (
      q.st != ST_IDLE && $past(q.st) != ST_IDLE && $past(clk_en_i) |-> $stable(q.act))
      else $error("settings changed during conversion");

   chk_tad_bound: assert property (
      q.div_cnt < adcc_tad_cycles(q.act.clk_sel))
      else $error("divider ran past the bit period");

   chk_rd_zero: assert property (
      psel_i && !penable_i && clk_en_i && paddr_i == `ADCC_OFF_CLKSEL |=> prdata_o[7] == 1'b0 && prdata_o[3:0] == 4'h0)
      else $error("unimplemented bits read nonzero");

   chk_off_idle: assert property (
      !q.main.en |-> !converter_enable_o && q.st == ST_IDLE)
      else $error("converter active while disabled");

   // Sequencing, flag and bus answer checks
   chk_go_level: assert property (
      q.main.go == (q.st == ST_SAMP || q.st == ST_CONV))
      else $error("go bit disagrees with sequencer state");

   chk_samp_to_conv: assert property (
      clk_en_i && !wr_main && q.st == ST_SAMP && tick
      |=> q.st == ST_CONV && q.code == 10'h200 && q.bit_idx == 4'h9)
      else $error("sample period did not hand over to conversion");

   chk_conv_bits: assert property (
      q.st == ST_CONV |-> q.bit_idx <= 4'h9)
      else $error("bit index out of range");

   chk_sar_clear: assert property (
      clk_en_i && q.st == ST_CONV && tick && !comp_i |=> !q.code[$past(q.bit_idx)])
      else $error("trial bit kept although comparator was low");

   chk_sar_keep: assert property (
      clk_en_i && q.st == ST_CONV && tick && comp_i |=> q.code[$past(q.bit_idx)])
      else $error("trial bit dropped although comparator was high");

   chk_abort_span: assert property (
      q.st == ST_ABORT |-> q.bit_idx <= 4'h1 && !q.main.go)
      else $error("abort wait overran or go set");

   chk_abort_exit: assert property (
      clk_en_i && q.st == ST_ABORT && tick && q.bit_idx == 4'h1 |=> q.st == ST_IDLE)
      else $error("abort wait did not end after two periods");

   chk_flag_sticky: assert property (
      clk_en_i && q.flag && !(wr && paddr_i == `ADCC_OFF_FLAG && pwdata_i[`ADCC_FLAG_BIT]) |=> q.flag)
      else $error("flag dropped without a clear");

   chk_flag_clear: assert property (
      wr && clk_en_i && paddr_i == `ADCC_OFF_FLAG && pwdata_i[`ADCC_FLAG_BIT] && !done |=> !q.flag)
      else $error("flag clear ignored");

   chk_idle_track: assert property (
      q.st == ST_IDLE
      |-> q.act.chan == q.main.chan && q.act.ref_sel == q.main.ref_sel && q.act.clk_sel == q.clk_sel)
      else $error("idle settings do not follow registers");

   chk_main_gap: assert property (
      psel_i && !penable_i && clk_en_i && paddr_i == `ADCC_OFF_MAIN |=> prdata_o[5] == 1'b0)
      else $error("unused control bit read nonzero");

   chk_rd_upper: assert property (
      prdata_o[31:8] == 24'h000000)
      else $error("upper read data nonzero");

   chk_err_ready: assert property (
      pslverr_o |-> pready_o)
      else $error("error without ready");

   chk_ready_pulse: assert property (
      clk_en_i && pready_o |=> !pready_o)
      else $error("ready longer than one cycle");

   chk_freeze: assert property (
      !clk_en_i |=> $stable(q))
      else $error("state moved while clock enable low");

   chk_off_write: assert property (
      wr_main && !pwdata_i[`ADCC_MAIN_EN] |=> q.st == ST_IDLE && !q.main.go && !converter_enable_o)
      else $error("disable write did not stop converter");

   chk_sample_enabled: assert property (
      sample_o |-> converter_enable_o)
      else $error("sampling while disabled");

   cov_complete: cover property (q.st == ST_CONV ##1 q.st == ST_IDLE && q.flag);
   cov_abort: cover property (q.st == ST_ABORT ##[1:600] q.st == ST_IDLE);
   cov_right_result: cover property (clk_en_i && done && q.main.justify);
   cov_frc: cover property (q.st == ST_SAMP && q.act.clk_sel[1:0] == 2'b11);
   cov_unmapped: cover property (pready_o && pslverr_o);

endmodule : adcc_top

// >>> shared/adcc_defs.svh
// Constants for the converter control block: offsets, field positions, reset values and timing.
// Assumes a 125 MHz system clock and an APB slave decoding the low address byte.
`ifndef ADCC_DEFS_SVH
`define ADCC_DEFS_SVH

// Register byte offsets
`define ADCC_OFF_MAIN 8'h00
`define ADCC_OFF_CLKSEL 8'h04
`define ADCC_OFF_RESH 8'h08
`define ADCC_OFF_RESL 8'h0C
`define ADCC_OFF_FLAG 8'h10

// Main control fields
`define ADCC_MAIN_JUSTIFY 7
`define ADCC_MAIN_REF 6
`define ADCC_MAIN_CHAN_HI 4
`define ADCC_MAIN_CHAN_LO 2
`define ADCC_MAIN_GO 1
`define ADCC_MAIN_EN 0

// Clock select and flag fields
`define ADCC_CLKSEL_HI 6
`define ADCC_CLKSEL_LO 4
`define ADCC_FLAG_BIT 0

// Reset values
`define ADCC_MAIN_RST 8'h00
`define ADCC_CLKSEL_RST 3'h0
`define ADCC_RES_RST 8'h00

// Timing
`define ADCC_SYS_CLK_NS 8
`define ADCC_FRC_MIN_PERIOD_NS 2000
`define ADCC_FRC_CYCLES (((`ADCC_FRC_MIN_PERIOD_NS) + (`ADCC_SYS_CLK_NS) - 1) / (`ADCC_SYS_CLK_NS))
`define ADCC_RES_BITS 10
`define ADCC_ABORT_TADS 2

`endif

// >>> shared/adcc_pkg.sv
// Types and the divider decode for the converter control block.
// Assumes adcc_defs.svh is on the include path.
`include "adcc_defs.svh"

package adcc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_SAMP = 4'b0010,
      ST_CONV = 4'b0100,
      ST_ABORT = 4'b1000
   } adcc_state_t;

   typedef struct packed {
      logic justify;
      logic ref_sel;
      logic [2:0] chan;
      logic go;
      logic en;
   } adcc_main_t;

   typedef struct packed {
      logic ref_sel;
      logic [2:0] chan;
      logic [2:0] clk_sel;
   } adcc_cfg_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } adcc_apb_rsp_t;

   typedef struct packed {
      adcc_main_t main;
      logic [2:0] clk_sel;
      logic [7:0] res_hi;
      logic [7:0] res_lo;
      logic flag;
      adcc_state_t st;
      adcc_cfg_t act;
      logic [7:0] div_cnt;
      logic [3:0] bit_idx;
      logic [9:0] code;
      adcc_apb_rsp_t apb;
      logic conv_en;
      logic sample;
      adcc_cfg_t out_cfg;
   } adcc_regs_t;

   // Conversion bit period in system clocks for a clock-select code
   function automatic logic [7:0] adcc_tad_cycles(input logic [2:0] sel);
      logic [7:0] n;
      n = 8'h02;
      if (sel[1:0] == 2'b11) begin
         n = 8'(`ADCC_FRC_CYCLES);
      end else begin
         n = 8'(8'h02 << {sel[1:0], sel[2]});
      end
      return n;
   endfunction : adcc_tad_cycles

endpackage : adcc_pkg

// >>> tb/adcc_src_model.sv
// Analog source model: one fixed level per channel and reference setting, compared with the trial code.
// Assumes the converter samples comp_o only on its bit-period ticks.
`timescale 1ns/1ps
module adcc_src_model (
   input wire logic [2:0] chan_i,
   input wire logic ref_i,
   input wire logic en_i,
   input wire logic [9:0] code_i,
   output logic comp_o
);
   logic [9:0] lvl;
   // Level depends on channel and reference so both choices show in the result
   assign lvl = 10'(10'h0CB + 10'h07D * chan_i) ^ {ref_i, 9'h000};
   assign comp_o = en_i & (lvl >= code_i);
endmodule : adcc_src_model

// >>> tb/adc_conversion_control_bench.sv
// Self-checking bench for the converter control block.
// Assumes adcc_top and adcc_src_model are compiled first.
`timescale 1ns/1ps
module adc_conversion_control_bench;
   import adcc_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic clk_en = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, comp, samp, en_o, ref_o, flag;
   logic [9:0] code, lv;
   logic [2:0] chan, ch;
   logic [2:0] cs [7] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3};
   int nt [7] = '{2, 4, 8, 16, 32, 64, 250};
   int mismatches = 0;
   int tests_run = 0;
   int cyc = 0;
   int t0, n;

   adcc_top u_adcc_top (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_en_i(clk_en), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .comp_i(comp), .code_o(code), .sample_o(samp),
      .converter_enable_o(en_o), .reference_select_o(ref_o), .channel_select_o(chan),
      .converter_interrupt_flag_o(flag));
   adcc_src_model u_adcc_src_model (.chan_i(chan), .ref_i(ref_o), .en_i(en_o), .code_i(code),
      .comp_o(comp));

   initial begin
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   always @(posedge ref_clk_i) cyc <= cyc + 1;

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int k;
      k = 0;
      @(posedge ref_clk_i);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge ref_clk_i);
      pen <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin
         mismatches++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end

   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h0);
      apb(1'b0, 8'h20, 8'h00);
      check({31'h0, err}, 32'h1);
      apb(1'b1, 8'h04, 8'hFF);
      apb(1'b0, 8'h04, 8'h00);
      check(rd, 32'h70);
      apb(1'b1, 8'h00, 8'h22);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h0);
      apb(1'b1, 8'h00, 8'h03);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h1);
      for (int i = 0; i < 7; i++) begin
         ch = i[2:0];
         // Configure first, enable, wait acquisition, then start
         apb(1'b1, 8'h04, {1'b0, cs[i], 4'h0});
         apb(1'b1, 8'h00, {ch[0], ~ch[0], 1'b0, ch, 2'b01});
         repeat (20) @(posedge ref_clk_i);
         t0 = cyc;
         apb(1'b1, 8'h00, {ch[0], ~ch[0], 1'b0, ch, 2'b11});
         check({31'h0, en_o}, 32'h1);
         apb(1'b0, 8'h00, 8'h00);
         check({31'h0, rd[1]}, 32'h1);
         n = 0;
         do begin
            apb(1'b0, 8'h00, 8'h00);
            n++;
         end while (rd[1] === 1'b1 && n < 2000);
         check({31'h0, rd[1]}, 32'h0);
         check(32'((cyc - t0 >= 10 * nt[i]) && (cyc - t0 <= 12 * nt[i] + 8)), 32'h1);
         lv = 10'(10'h0CB + 10'h07D * ch) ^ {~ch[0], 9'h000};
         check({29'h0, chan}, {29'h0, ch});
         check({31'h0, ref_o}, {31'h0, ~ch[0]});
         apb(1'b0, 8'h10, 8'h00);
         check(rd, 32'h1);
         check({31'h0, flag}, 32'h1);
         check({31'h0, samp}, 32'h1);
         apb(1'b0, 8'h08, 8'h00);
         check(rd, ch[0] ? {30'h0, lv[9:8]} : {24'h0, lv[9:2]});
         apb(1'b0, 8'h0C, 8'h00);
         check(rd, ch[0] ? {24'h0, lv[7:0]} : {24'h0, lv[1:0], 6'h0});
         apb(1'b1, 8'h10, 8'h01);
         apb(1'b0, 8'h10, 8'h00);
         check(rd, 32'h0);
         check({31'h0, flag}, 32'h0);
      end
      // Abort a slow conversion after a channel change
      apb(1'b1, 8'h00, 8'h5B);
      repeat (40) @(posedge ref_clk_i);
      apb(1'b1, 8'h00, 8'h4B);
      check({29'h0, chan}, 32'h6);
      apb(1'b1, 8'h00, 8'h49);
      apb(1'b0, 8'h00, 8'h00);
      check(rd, 32'h49);
      apb(1'b0, 8'h08, 8'h00);
      check(rd, {24'h0, lv[9:2]});
      apb(1'b0, 8'h10, 8'h00);
      check(rd, 32'h0);
      // Freeze the abort wait, which pushes the return to idle later
      clk_en <= 1'b0;
      repeat (300) @(posedge ref_clk_i);
      clk_en <= 1'b1;
      repeat (240) @(posedge ref_clk_i);
      check({29'h0, chan}, 32'h6);
      repeat (300) @(posedge ref_clk_i);
      check({29'h0, chan}, 32'h2);
      check({31'h0, samp}, 32'h1);
      apb(1'b1, 8'h00, 8'h00);
      apb(1'b0, 8'h00, 8'h00);
      check({30'h0, en_o, samp}, 32'h0);
      give_verdict();
   end
endmodule : adc_conversion_control_bench
